// >>> pkg/lasc_pkg.sv
/*
  Constants shared by the loop and status control block: register
  selects, status and configuration bit positions, widths, reset values.
  Assumes a core that addresses this block by register select codes.
*/
package lasc_pkg;
  ////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int ADDR_W  = 23;
  localparam int CNT_W   = 14;
  localparam int PAGE_W  = 8;
  localparam int DATA_W  = 16;
  localparam int LVL_W   = 4;
  ////////////////////////////////////////////////////////////////////////
  // Register select codes
  localparam logic [3:0] SEL_TBL   = 4'h0;
  localparam logic [3:0] SEL_PSV   = 4'h1;
  localparam logic [3:0] SEL_RCNT  = 4'h2;
  localparam logic [3:0] SEL_DCNT  = 4'h3;
  localparam logic [3:0] SEL_DBEG  = 4'h4;
  localparam logic [3:0] SEL_DEND  = 4'h5;
  localparam logic [3:0] SEL_SR    = 4'h6;
  localparam logic [3:0] SEL_CFG   = 4'h7;
  localparam logic [3:0] SEL_ECTL  = 4'h8;
  ////////////////////////////////////////////////////////////////////////
  // Status word bit positions
  localparam int SR_C   = 0;
  localparam int SR_Z   = 1;
  localparam int SR_OV  = 2;
  localparam int SR_N   = 3;
  localparam int SR_RA  = 4;
  localparam int SR_IPL = 5;
  localparam int SR_DC  = 8;
  localparam int SR_DA  = 9;
  localparam int SR_SAB = 10;
  localparam int SR_OAB = 11;
  localparam int SR_SB  = 12;
  localparam int SR_SA  = 13;
  localparam int SR_OB  = 14;
  localparam int SR_OA  = 15;
  ////////////////////////////////////////////////////////////////////////
  // Core configuration and exception control
  localparam int CFG_TRAP_PRIORITY_BIT = 3;
  localparam int CFG_EDT  = 11;
  localparam int ECTL_NST = 15;
  localparam logic [15:0] CFG_RST  = 16'h0020;
  localparam logic [15:0] CFG_MASK = 16'h10f7;
  ////////////////////////////////////////////////////////////////////////
  // Reset values and program counter step
  localparam logic [PAGE_W-1:0] PAGE_RST = 8'h00;
  localparam logic [CNT_W-1:0]  CNT_RST  = 14'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 23'h000000;
  localparam logic [ADDR_W-1:0] PC_STEP  = 23'h000002;
endpackage : lasc_pkg

// >>> verilog/lasc_shadow.sv
/*
  One-deep hidden shadow register: save copies the input, restore
  presents the held copy. Assumes save and restore never coincide.
*/
`timescale 1ns/1ps
`default_nettype none
module lasc_shadow #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_ce,
  // Shadow control
  input  wire logic         i_save,
  input  wire logic         i_restore,
  input  wire logic [W-1:0] i_data,
  output logic      [W-1:0] o_data,
  output logic              o_valid
);
  ////////////////////////////////////////////////////////////////////////
  logic [W-1:0] hold_q;
  logic         valid_q;

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      hold_q  <= '0;
      valid_q <= 1'b0;
    end
    else if (i_ce && i_save)
    begin
      hold_q  <= i_data;
      valid_q <= 1'b1;
    end
    else if (i_ce && i_restore)
      valid_q <= 1'b0;
  end

  assign o_data  = hold_q;
  assign o_valid = valid_q;
endmodule : lasc_shadow
`default_nettype wire

// >>> verilog/lasc_core.sv
/*
  Loop and status control of a 16-bit DSP core: page registers, repeat
  counter, hardware loop counter with shadow, status word, priority level.
  Assumes the core sequencer drives one-cycle event strobes on i_sys_clk.
*/
// Notes on behaviour
// - Table page gives upper eight address bits
// - View page selects mapped program region
// - Repeat count loads literal or register
// - Loop count loads literal or low bits
// - Loop start captures following instruction address
// - Loop end address branches to start
// - One-deep shadow for loop count, addresses
// - ALU reports C Z OV N DC
// - Zero flag normal for ordinary instructions
// - Fast save and restore of flags
// - Exception stacks low byte without nibble carry
// - Loop flag spans whole hardware loop
// - Repeat flag set and cleared by repeat
// - Writes to loop flags ignored; early exit
// - Restored zero repeat flag stops repeating
// - Guard spill flag follows guard bits
// - Clip flag sticky until software clear
// - Combined flags OR; combined clear clears both
// - Priority level from status and trap bit
// - Trap bit set only by hardware
// - Exception taken only above priority level
// - Servicing sets level; return restores IPL, not trap bit
// - Nesting block stops preemption
`timescale 1ns/1ps
`default_nettype none
module lasc_core (
  // Clock, reset, enable
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_ce,
  // Register access
  input  wire logic                        i_wr_en,
  input  wire logic [3:0]                  i_wr_sel,
  input  wire logic [15:0]                 i_wr_data,
  input  wire logic [3:0]                  i_rd_sel,
  output logic      [15:0]                 o_rd_data,
  // Instruction execution
  input  wire logic                        i_exec_valid,
  input  wire logic [lasc_pkg::ADDR_W-1:0] i_exec_pc,
  input  wire logic                        i_rpt_exec,
  input  wire logic                        i_rpt_step,
  input  wire logic                        i_do_exec,
  input  wire logic                        i_cnt_use_reg,
  input  wire logic [13:0]                 i_imm_count_literal,
  input  wire logic [15:0]                 i_cnt_reg,
  input  wire logic [lasc_pkg::ADDR_W-1:0] i_do_end_addr,
  // ALU and DSP results
  input  wire logic                        i_alu_upd,
  input  wire logic                        i_alu_carry_op,
  input  wire logic [4:0]                  i_alu_flags,
  input  wire logic                        i_fast_save,
  input  wire logic                        i_fast_restore,
  input  wire logic [1:0]                  i_acc_upd,
  input  wire logic [1:0]                  i_acc_guard,
  input  wire logic [1:0]                  i_acc_msb_ovf,
  // Exceptions
  input  wire logic                        i_exc_req,
  input  wire logic [3:0]                  i_exc_level,
  input  wire logic                        i_exc_busy,
  input  wire logic                        i_exc_ret,
  input  wire logic [7:0]                  i_stk_byte,
  input  wire logic                        i_trap_done,
  output logic                             o_exc_take,
  output logic      [7:0]                  o_stk_byte,
  // Control outputs
  output logic      [7:0]                  o_table_page_reg,
  output logic      [7:0]                  o_prog_view_page,
  output logic      [15:0]                 o_status_word,
  output logic                             o_branch_take,
  output logic      [lasc_pkg::ADDR_W-1:0] o_branch_addr
);
  ////////////////////////////////////////////////////////////////////////
  localparam int AW = lasc_pkg::ADDR_W;
  localparam int CW = lasc_pkg::CNT_W;
  localparam int SW = lasc_pkg::CNT_W + 2 * lasc_pkg::ADDR_W;

  function automatic logic hit(input logic en, input logic [3:0] sel,
                               input logic [3:0] want);
    return en && (sel == want);
  endfunction : hit

  function automatic logic [CW-1:0] pick_cnt(input logic use_reg,
                                             input logic [13:0] lit,
                                             input logic [15:0] rv);
    return use_reg ? rv[CW-1:0] : lit;
  endfunction : pick_cnt

  logic [7:0]    tbl_q, psv_q;
  logic [CW-1:0] rcnt_q, lcnt_q;
  logic [AW-1:0] lbeg_q, lend_q, baddr_q;
  logic          c_q, z_q, ov_q, n_q, dc_q, ra_q, da_q;
  logic [2:0]    ipl_q;
  logic [1:0]    oa_q, sa_q;
  logic          trap_priority_bit_q, edt_q, nest_q, take_q, br_q;
  logic [15:0]   cfg_q, rd_q;
  logic [7:0]    stk_q;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  ////////////////////////////////////////////////////////////////////////
  // Register writes
  wire w_tbl  = hit(i_wr_en, i_wr_sel, lasc_pkg::SEL_TBL);
  wire w_psv  = hit(i_wr_en, i_wr_sel, lasc_pkg::SEL_PSV);
  wire w_rcnt = hit(i_wr_en, i_wr_sel, lasc_pkg::SEL_RCNT);
  wire w_dcnt = hit(i_wr_en, i_wr_sel, lasc_pkg::SEL_DCNT);
  wire w_dbeg = hit(i_wr_en, i_wr_sel, lasc_pkg::SEL_DBEG);
  wire w_dend = hit(i_wr_en, i_wr_sel, lasc_pkg::SEL_DEND);
  wire w_sr   = hit(i_wr_en, i_wr_sel, lasc_pkg::SEL_SR);
  wire w_cfg  = hit(i_wr_en, i_wr_sel, lasc_pkg::SEL_CFG);
  wire w_ectl = hit(i_wr_en, i_wr_sel, lasc_pkg::SEL_ECTL);

  ////////////////////////////////////////////////////////////////////////
  // Repeat loop
  wire [CW-1:0] w_rpt_cnt = pick_cnt(i_cnt_use_reg, i_imm_count_literal,
                                     i_cnt_reg);
  wire          w_rpt_last = i_rpt_step && ra_q && (rcnt_q == '0);
  wire [CW-1:0] w_rcnt_d = i_rpt_exec ? w_rpt_cnt :
                         (i_rpt_step && ra_q && !w_rpt_last) ?
                           rcnt_q - 1'b1 :
                         w_rcnt ? i_wr_data[CW-1:0] : rcnt_q;
  // Flag is stacked, so a handler may stop the loop through it
  wire w_ra_d = i_exc_ret ? i_stk_byte[lasc_pkg::SR_RA] :
                i_rpt_exec ? 1'b1 :
                w_rpt_last ? 1'b0 : ra_q;

  ////////////////////////////////////////////////////////////////////////
  // Hardware loop
  wire [CW-1:0] w_do_cnt = pick_cnt(i_cnt_use_reg, i_imm_count_literal,
                                    i_cnt_reg);
  wire [AW-1:0] w_next_pc = i_exec_pc + lasc_pkg::PC_STEP;
  wire w_end_hit = da_q && i_exec_valid && (i_exec_pc == lend_q);
  wire w_done    = w_end_hit && ((lcnt_q == '0) || edt_q);
  wire [SW-1:0] w_sh_out;
  wire          w_sh_valid;
  wire w_sh_save = i_do_exec && da_q;
  wire w_sh_rest = w_done && w_sh_valid;

  lasc_shadow #(.W(SW)) u_loop_shadow (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .i_save    (w_sh_save),
    .i_restore (w_sh_rest),
    .i_data    ({lcnt_q, lbeg_q, lend_q}),
    .o_data    (w_sh_out),
    .o_valid   (w_sh_valid)
  );

  wire [CW-1:0] w_lcnt_d = i_do_exec ? w_do_cnt :
                         w_sh_rest ? w_sh_out[SW-1 -: CW] :
                         (w_end_hit && !w_done) ? lcnt_q - 1'b1 :
                         w_dcnt ? i_wr_data[CW-1:0] : lcnt_q;
  wire [AW-1:0] w_lbeg_d = i_do_exec ? w_next_pc :
                         w_sh_rest ? w_sh_out[2*AW-1 -: AW] :
                         w_dbeg ? {7'h00, i_wr_data} : lbeg_q;
  wire [AW-1:0] w_lend_d = i_do_exec ? i_do_end_addr :
                         w_sh_rest ? w_sh_out[AW-1:0] :
                         w_dend ? {7'h00, i_wr_data} : lend_q;
  // Software cannot start or stop the loop through this flag
  wire w_da_d = i_do_exec ? 1'b1 :
                (w_done && !w_sh_valid) ? 1'b0 : da_q;
  // Early exit request is consumed when the loop ends; a new write wins
  wire w_edt_d = (w_cfg && i_wr_data[lasc_pkg::CFG_EDT]) ? 1'b1 :
                 w_done ? 1'b0 : edt_q;

  ////////////////////////////////////////////////////////////////////////
  // ALU flags {dc, n, ov, z, c}
  wire [4:0] w_fast;
  lasc_shadow #(.W(5)) u_flag_shadow (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .i_save    (i_fast_save),
    .i_restore (i_fast_restore),
    .i_data    ({dc_q, n_q, ov_q, z_q, c_q}),
    .o_data    (w_fast),
    .o_valid   ()
  );

  wire [7:0] w_sr_low = {ipl_q, ra_q, n_q, ov_q, z_q, c_q};
  // Multiword compares keep zero across words
  wire w_alu_z = i_alu_carry_op ? (z_q & i_alu_flags[1]) :
                 i_alu_flags[1];
  wire [4:0] w_alu = {i_alu_flags[4:2], w_alu_z, i_alu_flags[0]};
  wire [4:0] w_sw_fl = {i_wr_data[lasc_pkg::SR_DC],
                        i_wr_data[lasc_pkg::SR_N:lasc_pkg::SR_C]};
  wire [4:0] w_fl_mux = i_fast_restore ? w_fast :
                        i_alu_upd ? w_alu :
                        w_sr ? w_sw_fl :
                        {dc_q, n_q, ov_q, z_q, c_q};
  // Nibble carry is not in the stacked byte and survives return
  wire [4:0] w_fl_d = i_exc_ret ?
                      {w_fl_mux[4], i_stk_byte[3:0]} : w_fl_mux;

  ////////////////////////////////////////////////////////////////////////
  // Accumulator flags, index 0 is A
  wire [1:0] w_sa_clr = (w_sr && !i_wr_data[lasc_pkg::SR_SAB]) ? 2'b11 :
                        w_sr ? ~{i_wr_data[lasc_pkg::SR_SB],
                                 i_wr_data[lasc_pkg::SR_SA]} : 2'b00;
  wire [1:0] w_sa_set = i_acc_upd & i_acc_msb_ovf;
  wire [1:0] w_sa_d = w_sa_set | (sa_q & ~w_sa_clr);
  wire [1:0] w_oa_d = (i_acc_upd & i_acc_guard) |
                      (~i_acc_upd & oa_q);

  ////////////////////////////////////////////////////////////////////////
  // Priority level and exception entry
  wire [3:0] w_cpu_lvl = {trap_priority_bit_q, ipl_q};
  wire w_take = i_exc_req && (i_exc_level > w_cpu_lvl) &&
                !(nest_q && i_exc_busy);
  wire [2:0] w_ipl_d = w_take ? i_exc_level[2:0] :
                       i_exc_ret ? i_stk_byte[7:5] :
                       w_sr ? i_wr_data[7:5] : ipl_q;
  // Software may only clear the trap bit; a trap entry wins
  wire w_trap_priority_bit_d = (w_take && i_exc_level[3]) ? 1'b1 :
                  i_trap_done ? 1'b0 :
                  (w_cfg && !i_wr_data[lasc_pkg::CFG_TRAP_PRIORITY_BIT]) ? 1'b0 :
                  trap_priority_bit_q;

  ////////////////////////////////////////////////////////////////////////
  // Read path
  wire [15:0] w_sr_full = {oa_q[0], oa_q[1], sa_q[0], sa_q[1],
                           |oa_q, |sa_q, da_q, dc_q, w_sr_low};
  wire [15:0] w_cfg_rd = (cfg_q & lasc_pkg::CFG_MASK) |
                         {12'h000, trap_priority_bit_q, 3'h0};
  logic [15:0] w_rd;
  always_comb
  begin
    case (i_rd_sel)
      lasc_pkg::SEL_TBL:  w_rd = {8'h00, tbl_q};
      lasc_pkg::SEL_PSV:  w_rd = {8'h00, psv_q};
      lasc_pkg::SEL_RCNT: w_rd = {2'h0, rcnt_q};
      lasc_pkg::SEL_DCNT: w_rd = {2'h0, lcnt_q};
      lasc_pkg::SEL_DBEG: w_rd = lbeg_q[15:0];
      lasc_pkg::SEL_DEND: w_rd = lend_q[15:0];
      lasc_pkg::SEL_SR:   w_rd = w_sr_full;
      lasc_pkg::SEL_CFG:  w_rd = w_cfg_rd;
      lasc_pkg::SEL_ECTL: w_rd = {nest_q, 15'h0000};
      default:            w_rd = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tbl_q  <= lasc_pkg::PAGE_RST;
      psv_q  <= lasc_pkg::PAGE_RST;
      rcnt_q <= lasc_pkg::CNT_RST;
      lcnt_q <= lasc_pkg::CNT_RST;
      lbeg_q <= lasc_pkg::ADDR_RST;
      lend_q <= lasc_pkg::ADDR_RST;
      {dc_q, n_q, ov_q, z_q, c_q} <= 5'h00;
      {ra_q, da_q, edt_q, trap_priority_bit_q, nest_q} <= 5'h00;
      ipl_q  <= 3'h0;
      {oa_q, sa_q} <= 4'h0;
      cfg_q  <= lasc_pkg::CFG_RST;
    end
    else if (i_ce)
    begin
      if (w_tbl) tbl_q <= i_wr_data[7:0];
      if (w_psv) psv_q <= i_wr_data[7:0];
      if (w_cfg) cfg_q <= i_wr_data;
      if (w_ectl) nest_q <= i_wr_data[lasc_pkg::ECTL_NST];
      rcnt_q <= w_rcnt_d;
      lcnt_q <= w_lcnt_d;
      lbeg_q <= w_lbeg_d;
      lend_q <= w_lend_d;
      {dc_q, n_q, ov_q, z_q, c_q} <= w_fl_d;
      ra_q   <= w_ra_d;
      da_q   <= w_da_d;
      edt_q  <= w_edt_d;
      ipl_q  <= w_ipl_d;
      trap_priority_bit_q <= w_trap_priority_bit_d;
      oa_q   <= w_oa_d;
      sa_q   <= w_sa_d;
    end
  end

  // Branch is registered, so the fetch unit must redirect in the
  // cycle it is presented to stay free of extra cycles
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      {take_q, br_q} <= 2'b00;
      {stk_q, rd_q}  <= 24'h000000;
      baddr_q        <= lasc_pkg::ADDR_RST;
    end
    else if (i_ce)
    begin
      take_q  <= w_take;
      stk_q   <= w_take ? w_sr_low : stk_q;
      br_q    <= w_end_hit && !w_done;
      baddr_q <= lbeg_q;
      rd_q    <= w_rd;
    end
  end

  assign o_rd_data        = rd_q;
  assign o_exc_take       = take_q;
  assign o_stk_byte       = stk_q;
  assign o_table_page_reg = tbl_q;
  assign o_prog_view_page = psv_q;
  assign o_status_word    = w_sr_full;
  assign o_branch_take    = br_q;
  assign o_branch_addr    = baddr_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_rpt_load: assert property (i_ce && i_rpt_exec && !i_exc_ret |=>
    ra_q && rcnt_q == $past(w_rpt_cnt))
    else $error("repeat load wrong");
  a_do_count: assert property (i_ce && i_do_exec |=>
    lcnt_q == $past(w_do_cnt) && da_q)
    else $error("loop count load wrong");
  a_do_start: assert property (i_ce && i_do_exec |=>
    lbeg_q == $past(w_next_pc))
    else $error("loop start not next address");
  a_loop_branch: assert property (i_ce && w_end_hit && !w_done |=>
    o_branch_take && o_branch_addr == $past(lbeg_q))
    else $error("loop end did not branch");
  a_shadow_nest: assert property (i_ce && w_sh_rest && !i_do_exec |=>
    da_q && lend_q == $past(w_sh_out[AW-1:0]))
    else $error("outer loop not restored");
  a_zero_sticky: assert property (i_ce && i_alu_upd && i_alu_carry_op &&
    !i_fast_restore && !i_exc_ret && !z_q |=> !z_q)
    else $error("carry op set zero flag");
  a_clip_sticky: assert property (i_ce && |w_sa_set |=>
    o_status_word[lasc_pkg::SR_SAB])
    else $error("clip flag not set");
  a_take_level: assert property (o_exc_take && $past(i_ce) |->
    $past(i_exc_level) > $past(w_cpu_lvl))
    else $error("exception taken at low level");
  a_enter_level: assert property (i_ce && w_take |=>
    w_cpu_lvl == $past(i_exc_level))
    else $error("level not set on entry");
  a_ra_return: assert property (i_ce && i_exc_ret &&
    !i_stk_byte[lasc_pkg::SR_RA] |=> !ra_q)
    else $error("repeat flag not restored");
  a_nest_block: assert property (i_ce && nest_q && i_exc_busy |=>
    !o_exc_take)
    else $error("nested exception taken");

  c_loop_wrap: cover property (o_branch_take ##[1:20] o_branch_take);
  c_trap_take: cover property (o_exc_take && trap_priority_bit_q);
  c_nest_done: cover property (i_ce && w_sh_rest);
  c_rpt_end:   cover property (i_ce && w_rpt_last);
endmodule : lasc_core
`default_nettype wire

// >>> testbench/tb_loop_and_status_control.sv
/*
  Self-checking bench for the loop and status control core: pages,
  status word, repeat and hardware loops, exceptions.
  Assumes lasc_pkg and lasc_core are compiled before this file.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_loop_and_status_control;
  logic        clk, rst_n, wr_en, ev, rpt, rstep, do_x, use_reg, alu, cop;
  logic        fs, fr, xreq, busy, xret, tdone, take, btake, ce;
  logic [3:0]  wsel, rsel, lvl;
  logic [15:0] wdat, rdat, creg, sr;
  logic [13:0] lit;
  logic [22:0] pc, dend, baddr;
  logic [4:0]  flags;
  logic [1:0]  aupd, agrd, aovf;
  logic [7:0]  sbi, sbo, tpg, pvp;
  int          n_fail = 0;
  int          total_checks = 0;
  int          cyc = 0;
  //////////////////////////////////////////////////////////////////////////
  lasc_core dut_u (.i_sys_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
    .i_wr_en(wr_en), .i_wr_sel(wsel), .i_wr_data(wdat), .i_rd_sel(rsel),
    .o_rd_data(rdat), .i_exec_valid(ev), .i_exec_pc(pc), .i_rpt_exec(rpt),
    .i_rpt_step(rstep), .i_do_exec(do_x), .i_cnt_use_reg(use_reg),
    .i_imm_count_literal(lit), .i_cnt_reg(creg), .i_do_end_addr(dend),
    .i_alu_upd(alu), .i_alu_carry_op(cop), .i_alu_flags(flags),
    .i_fast_save(fs), .i_fast_restore(fr), .i_acc_upd(aupd),
    .i_acc_guard(agrd), .i_acc_msb_ovf(aovf), .i_exc_req(xreq),
    .i_exc_level(lvl), .i_exc_busy(busy), .i_exc_ret(xret),
    .i_stk_byte(sbi), .i_trap_done(tdone), .o_exc_take(take),
    .o_stk_byte(sbo), .o_table_page_reg(tpg), .o_prog_view_page(pvp),
    .o_status_word(sr), .o_branch_take(btake), .o_branch_addr(baddr));
  //////////////////////////////////////////////////////////////////////////
  task automatic step(int n = 1);
    repeat (n) @(negedge clk);
  endtask : step
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  // Trailing idle cycle keeps the strobe from toggling twice in one step
  task automatic wr(logic [3:0] s, logic [15:0] d);
    wr_en = 1'b1;
    wsel = s;
    wdat = d;
    step();
    wr_en = 1'b0;
    step();
  endtask : wr
  task automatic rd(logic [3:0] s, logic [15:0] e, string nm);
    rsel = s;
    step();
    chk(nm, e, rdat);
  endtask : rd
  task automatic alu_op(logic c, logic [4:0] f, logic [4:0] e);
    alu = 1'b1;
    cop = c;
    flags = f;
    step();
    alu = 1'b0;
    step();
    chk("alu_flags", {11'h000, e}, {11'h000, sr[8], sr[3:0]});
  endtask : alu_op
  task automatic acc(logic [1:0] g, logic [1:0] o, logic [5:0] e);
    aupd = 2'b11;
    agrd = g;
    aovf = o;
    step();
    aupd = 2'b00;
    step();
    chk("acc_flags", {10'h000, e}, {10'h000, sr[15:10]});
  endtask : acc
  task automatic do_ins(logic [22:0] a, logic [22:0] e);
    pc = a;
    dend = e;
    do_x = 1'b1;
    step();
    do_x = 1'b0;
    step();
  endtask : do_ins
  // Branch is registered, so two cycles are watched after the end pass
  task automatic end_hit(logic [22:0] a, logic eb, logic [15:0] ea);
    logic seen;
    seen = 1'b0;
    pc = a;
    ev = 1'b1;
    step();
    ev = 1'b0;
    repeat (2)
    begin
      if (btake === 1'b1)
      begin
        seen = 1'b1;
        chk("branch_addr", ea, baddr[15:0]);
      end
      step();
    end
    chk("branch_take", {15'h0000, eb}, {15'h0000, seen});
  endtask : end_hit
  task automatic exc(logic [3:0] l, logic e);
    logic seen;
    seen = 1'b0;
    lvl = l;
    xreq = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      step();
      if (take === 1'b1)
        seen = 1'b1;
      xreq = xreq & ~seen & (i < 3);
    end
    step();
    chk("exc_take", {15'h0000, e}, {15'h0000, seen});
  endtask : exc
  //////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    chk("status_reset", 16'h0000, sr);
    wr(lasc_pkg::SEL_TBL, 16'h00a5);
    chk("table_page", 16'h00a5, {8'h00, tpg});
    ce = 1'b0;
    wr(lasc_pkg::SEL_TBL, 16'h0011);
    ce = 1'b1;
    chk("table_freeze", 16'h00a5, {8'h00, tpg});
    wr(lasc_pkg::SEL_PSV, 16'h005a);
    chk("view_page", 16'h005a, {8'h00, pvp});
    rd(lasc_pkg::SEL_TBL, 16'h00a5, "rd_table");
    rd(4'hf, 16'h0000, "rd_unmapped");
    wr(lasc_pkg::SEL_SR, 16'hffff);
    chk("status_ro", 16'h01ef, sr);
    wr(lasc_pkg::SEL_SR, 16'h0000);
  endtask : t_regs
  task automatic t_alu;
    alu_op(1'b0, 5'b10011, 5'b10011);
    alu_op(1'b1, 5'b00011, 5'b00011);
    fs = 1'b1;
    step();
    fs = 1'b0;
    alu_op(1'b1, 5'b01001, 5'b01001);
    alu_op(1'b1, 5'b00011, 5'b00001);
    fr = 1'b1;
    step();
    fr = 1'b0;
    step();
    chk("restored", 16'h0003, {11'h000, sr[8], sr[3:0]});
  endtask : t_alu
  task automatic t_acc;
    acc(2'b01, 2'b10, 6'b100111);
    acc(2'b00, 2'b00, 6'b000101);
    wr(lasc_pkg::SEL_SR, 16'h3000);
    chk("clip_clear", 16'h0000, {10'h000, sr[15:10]});
  endtask : t_acc
  task automatic t_rpt;
    use_reg = 1'b1;
    creg = 16'hc002;
    rpt = 1'b1;
    step();
    rpt = 1'b0;
    chk("rpt_flag", 16'h0001, {15'h0000, sr[4]});
    rd(lasc_pkg::SEL_RCNT, 16'h0002, "rpt_count");
    rstep = 1'b1;
    step(2);
    chk("rpt_busy", 16'h0001, {15'h0000, sr[4]});
    step();
    rstep = 1'b0;
    chk("rpt_done", 16'h0000, {15'h0000, sr[4]});
  endtask : t_rpt
  task automatic t_loop;
    creg = 16'hc001;
    do_ins(23'h000100, 23'h000108);
    chk("loop_flag", 16'h0001, {15'h0000, sr[9]});
    rd(lasc_pkg::SEL_DBEG, 16'h0102, "loop_begin");
    rd(lasc_pkg::SEL_DCNT, 16'h0001, "loop_count");
    end_hit(23'h000108, 1'b1, 16'h0102);
    use_reg = 1'b0;
    lit = 14'h0000;
    do_ins(23'h000102, 23'h000104);
    end_hit(23'h000104, 1'b0, 16'h0000);
    chk("outer_flag", 16'h0001, {15'h0000, sr[9]});
    rd(lasc_pkg::SEL_DEND, 16'h0108, "outer_end");
    end_hit(23'h000108, 1'b0, 16'h0000);
    chk("loop_clear", 16'h0000, {15'h0000, sr[9]});
  endtask : t_loop
  task automatic t_exc;
    wr(lasc_pkg::SEL_SR, 16'h0160);
    creg = 16'h0005;
    use_reg = 1'b1;
    rpt = 1'b1;
    step();
    rpt = 1'b0;
    exc(4'h3, 1'b0);
    exc(4'h4, 1'b1);
    chk("stk_byte", 16'h0070, {8'h00, sbo});
    chk("ipl_take", 16'h0004, {13'h0000, sr[7:5]});
    sbi = 8'h60;
    xret = 1'b1;
    step();
    xret = 1'b0;
    step();
    chk("ipl_ret", 16'h0016, {11'h000, sr[8:4]});
    busy = 1'b1;
    exc(4'hc, 1'b1);
    rd(lasc_pkg::SEL_CFG, 16'h0028, "trap_bit");
    wr(lasc_pkg::SEL_ECTL, 16'h8000);
    exc(4'hf, 1'b0);
    tdone = 1'b1;
    step();
    tdone = 1'b0;
    wr(lasc_pkg::SEL_CFG, 16'h0028);
    rd(lasc_pkg::SEL_CFG, 16'h0020, "trap_clear");
  endtask : t_exc
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Cut a hang short well beyond the hundred or so cycles the run needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      stop_test();
    end
  end
  initial
  begin
    {rst_n, wr_en, ev, rpt, rstep, do_x, use_reg, alu, cop} = '0;
    {fs, fr, xreq, busy, xret, tdone} = '0;
    ce = 1'b1;
    {wsel, rsel, lvl, wdat, creg, lit, pc, dend} = '0;
    {flags, aupd, agrd, aovf, sbi} = '0;
    repeat (16) @(posedge clk);
    step();
    rst_n = 1'b1;
    step();
    t_regs();
    t_alu();
    t_acc();
    t_rpt();
    t_loop();
    t_exc();
    stop_test();
  end
endmodule : tb_loop_and_status_control
`default_nettype wire
